// ===== design/pbw_bridge.sv
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - plain access completes in 3 + m clocks
// - eight-bit wait select register, software read/write
// - wait select at fixed address, resets 77h
// - setting 00h no waits, 01h one wait
// - conflict-prone peripherals get lengthened access cycles
// - cpu stalls via waitrequest for all waits
// - special registers add extra waits over base
// - extra waits equal (2 + m) times k
// - special access lasts 3 + m + (2+m)k
// - watchdog one mode write: k 1..5
// - watchdog two mode write: k fixed 3
// - timer p reads formula k; compare writes 0..2
// - timer control read-modify-write: k 1 on write
// - auto serial buffer writes: k 0..18 or 0..20
// - async serial status reads: k fixed 1
// - realtime buffer write, enable low: k 1
module pbw_bridge #(
   parameter int CLK_RATIO = 1,
   parameter logic [31:0] WDT1_ADDR = 32'h00000100,
   parameter logic [31:0] WDT2_ADDR = 32'h00000104,
   parameter logic [31:0] TP_CMP0_ADDR = 32'h00000200,
   parameter logic [31:0] TP_CMP1_ADDR = 32'h00000204,
   parameter logic [31:0] TP_CNT_ADDR = 32'h00000208,
   parameter logic [31:0] TMC_BASE = 32'h00000300,
   parameter logic [31:0] CSI_BASE = 32'h00000400,
   parameter logic [31:0] ASY_BASE = 32'h00000500,
   parameter logic [31:0] IIC_STAT_ADDR = 32'h00000510,
   parameter logic [31:0] RTB_BASE = 32'h00000600
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [31:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic cpu_rmw,
   input wire logic [4:0] per_hold_k,
   input wire logic per_rx_conflict,
   input wire logic realtime_output_enable,
   input wire logic [31:0] per_rdata,
   output logic per_sel,
   output logic per_we,
   output logic [31:0] per_addr,
   output logic [31:0] per_wdata,
   output logic [3:0] per_be,
   output logic [7:0] peripheral_wait_select
);

   // refused at elaboration: ratios below 1, and ratios too large for the k field
   if (CLK_RATIO < 1) begin : g_ratio_low
      $error("CLK_RATIO must be at least 1");
   end
   if (CLK_RATIO > 60) begin : g_ratio_high
      $error("CLK_RATIO too large for a five bit k");
   end

   // the span decode counts four-byte words up from each byte-address base, so every base is aligned
   if (WDT1_ADDR[1:0] != 2'h0) begin : g_al_wdt1
      $error("WDT1_ADDR must be word aligned");
   end
   if (WDT2_ADDR[1:0] != 2'h0) begin : g_al_wdt2
      $error("WDT2_ADDR must be word aligned");
   end
   if (TP_CMP0_ADDR[1:0] != 2'h0) begin : g_al_cmp0
      $error("TP_CMP0_ADDR must be word aligned");
   end
   if (TP_CMP1_ADDR[1:0] != 2'h0) begin : g_al_cmp1
      $error("TP_CMP1_ADDR must be word aligned");
   end
   if (TP_CNT_ADDR[1:0] != 2'h0) begin : g_al_cnt
      $error("TP_CNT_ADDR must be word aligned");
   end
   if (TMC_BASE[1:0] != 2'h0) begin : g_al_tmc
      $error("TMC_BASE must be word aligned");
   end
   if (CSI_BASE[1:0] != 2'h0) begin : g_al_csi
      $error("CSI_BASE must be word aligned");
   end
   if (ASY_BASE[1:0] != 2'h0) begin : g_al_asy
      $error("ASY_BASE must be word aligned");
   end
   if (IIC_STAT_ADDR[1:0] != 2'h0) begin : g_al_iic
      $error("IIC_STAT_ADDR must be word aligned");
   end
   if (RTB_BASE[1:0] != 2'h0) begin : g_al_rtb
      $error("RTB_BASE must be word aligned");
   end

   // a special address on the wait register would be hidden behind its base-only timing
   if (WDT1_ADDR == pbw_pkg::WAIT_SEL_ADDR) begin : g_cl_wdt1
      $error("WDT1_ADDR collides with the wait register");
   end
   if (WDT2_ADDR == pbw_pkg::WAIT_SEL_ADDR) begin : g_cl_wdt2
      $error("WDT2_ADDR collides with the wait register");
   end
   if (TP_CMP0_ADDR == pbw_pkg::WAIT_SEL_ADDR) begin : g_cl_cmp0
      $error("TP_CMP0_ADDR collides with the wait register");
   end
   if (TP_CMP1_ADDR == pbw_pkg::WAIT_SEL_ADDR) begin : g_cl_cmp1
      $error("TP_CMP1_ADDR collides with the wait register");
   end
   if (TP_CNT_ADDR == pbw_pkg::WAIT_SEL_ADDR) begin : g_cl_cnt
      $error("TP_CNT_ADDR collides with the wait register");
   end
   if (TMC_BASE == pbw_pkg::WAIT_SEL_ADDR) begin : g_cl_tmc
      $error("TMC_BASE collides with the wait register");
   end
   if (CSI_BASE == pbw_pkg::WAIT_SEL_ADDR) begin : g_cl_csi
      $error("CSI_BASE collides with the wait register");
   end
   if (ASY_BASE == pbw_pkg::WAIT_SEL_ADDR) begin : g_cl_asy
      $error("ASY_BASE collides with the wait register");
   end
   if (IIC_STAT_ADDR == pbw_pkg::WAIT_SEL_ADDR) begin : g_cl_iic
      $error("IIC_STAT_ADDR collides with the wait register");
   end
   if (RTB_BASE == pbw_pkg::WAIT_SEL_ADDR) begin : g_cl_rtb
      $error("RTB_BASE collides with the wait register");
   end

   // overlapping spans would let the earlier class shadow the later one
   if (CSI_BASE < ASY_BASE &&
         CSI_BASE + 32'(4 * pbw_pkg::SER_SPAN) > ASY_BASE) begin : g_ov_csi
      $error("serial buffer span overlaps status span");
   end
   if (TMC_BASE < CSI_BASE &&
         TMC_BASE + 32'(4 * pbw_pkg::TMC_SPAN) > CSI_BASE) begin : g_ov_tmc
      $error("timer control span overlaps serial buffer span");
   end

   typedef enum logic [1:0] {
      PBW_IDLE,
      PBW_COUNT,
      PBW_DONE
   } pbw_state_type;

   pbw_state_type state_ff;
   pbw_state_type nxt_state;
   logic [pbw_pkg::CNT_W-1:0] cnt_ff;
   logic [pbw_pkg::CNT_W-1:0] nxt_cnt;
   logic [7:0] wait_sel_ff;
   logic [31:0] rdata_ff;
   pbw_pkg::pbw_req_type req_ff;
   logic is_wait_reg_ff;
   logic req;
   logic [2:0] m_val;
   pbw_pkg::pbw_class_type cls;
   logic [4:0] k_val;

   function automatic logic in_span(input logic [31:0] a,
         input logic [31:0] base, input int n);
      logic [31:0] lim;
      lim = base + 32'(4 * n);
      return (a >= base) && (a < lim);
   endfunction

   function automatic logic [4:0] clamp_k(input logic [4:0] k,
         input logic [4:0] lo, input logic [4:0] hi);
      logic [4:0] r;
      r = k;
      if (k < lo) begin
         r = lo;
      end else if (k > hi) begin
         r = hi;
      end
      return r;
   endfunction

   // count loaded after the first cycle: m + (2 + m) * k
   function automatic logic [pbw_pkg::CNT_W-1:0] wait_count(
         input logic [2:0] m, input logic [4:0] k);
      logic [pbw_pkg::CNT_W-1:0] f;
      f = pbw_pkg::CNT_W'(pbw_pkg::EXTRA_BASE) + pbw_pkg::CNT_W'(m);
      return pbw_pkg::CNT_W'(m) +
             pbw_pkg::CNT_W'(f * pbw_pkg::CNT_W'(k));
   endfunction

   function automatic pbw_pkg::pbw_class_type classify(
         input logic [31:0] a, input logic wr, input logic rmw);
      pbw_pkg::pbw_class_type c;
      c = pbw_pkg::PBW_PLAIN;
      if (wr && a == WDT1_ADDR) begin
         c = pbw_pkg::PBW_WDT1_WR;
      end else if (wr && a == WDT2_ADDR) begin
         c = pbw_pkg::PBW_WDT2_WR;
      end else if (a == TP_CMP0_ADDR || a == TP_CMP1_ADDR) begin
         c = wr ? pbw_pkg::PBW_TP_WR : pbw_pkg::PBW_TP_RD;
      end else if (!wr && a == TP_CNT_ADDR) begin
         c = pbw_pkg::PBW_TP_RD;
      end else if (wr && rmw &&
            in_span(a, TMC_BASE, pbw_pkg::TMC_SPAN)) begin
         c = pbw_pkg::PBW_TMC_RMW;
      end else if (wr && in_span(a, CSI_BASE, pbw_pkg::SER_SPAN)) begin
         c = pbw_pkg::PBW_CSI_WR;
      end else if (!wr && (a == IIC_STAT_ADDR ||
            in_span(a, ASY_BASE, pbw_pkg::ASY_SPAN))) begin
         c = pbw_pkg::PBW_STAT_RD;
      end else if (wr && in_span(a, RTB_BASE, pbw_pkg::RTB_SPAN)) begin
         c = pbw_pkg::PBW_RTB_WR;
      end
      return c;
   endfunction

   assign req = avs_read | avs_write;
   assign m_val = wait_sel_ff[pbw_pkg::WAIT_M_MSB:pbw_pkg::WAIT_M_LSB];
   assign cls = classify(avs_address, avs_write, cpu_rmw);

   // k per register class; ranged cases follow the peripheral's demand
   always_comb begin
      k_val = pbw_pkg::K_ZERO;
      case (cls)
         pbw_pkg::PBW_WDT1_WR:
            k_val = clamp_k(per_hold_k, pbw_pkg::K_ONE,
                            pbw_pkg::K_FIVE);
         pbw_pkg::PBW_WDT2_WR:
            k_val = pbw_pkg::K_THREE;
         pbw_pkg::PBW_TP_RD:
            k_val = 5'(CLK_RATIO / (pbw_pkg::EXTRA_BASE + int'(m_val))) +
                    pbw_pkg::K_ONE;
         pbw_pkg::PBW_TP_WR:
            k_val = clamp_k(per_hold_k, pbw_pkg::K_ZERO,
                            pbw_pkg::K_TWO);
         pbw_pkg::PBW_TMC_RMW:
            k_val = pbw_pkg::K_ONE;
         pbw_pkg::PBW_CSI_WR:
            k_val = clamp_k(per_hold_k, pbw_pkg::K_ZERO,
                            per_rx_conflict ? pbw_pkg::K_CSI_RX_MAX :
                            pbw_pkg::K_CSI_MAX);
         pbw_pkg::PBW_STAT_RD:
            k_val = pbw_pkg::K_ONE;
         pbw_pkg::PBW_RTB_WR:
            k_val = realtime_output_enable ? pbw_pkg::K_ZERO :
                    pbw_pkg::K_ONE;
         default:
            k_val = pbw_pkg::K_ZERO;
      endcase
   end

   // the wait register itself never sees a conflict, so only base waits
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      case (state_ff)
         PBW_IDLE: begin
            if (req) begin
               nxt_state = PBW_COUNT;
               if (avs_address == pbw_pkg::WAIT_SEL_ADDR) begin
                  nxt_cnt = wait_count(m_val, pbw_pkg::K_ZERO);
               end else begin
                  nxt_cnt = wait_count(m_val, k_val);
               end
            end
         end
         PBW_COUNT: begin
            if (cnt_ff == '0) begin
               nxt_state = PBW_DONE;
            end else begin
               nxt_cnt = cnt_ff - pbw_pkg::CNT_W'(1);
            end
         end
         PBW_DONE: begin
            nxt_state = PBW_IDLE;
         end
         default: begin
            nxt_state = PBW_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= PBW_IDLE;
         cnt_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
      end
   end

   // request latched at acceptance; the master holds it anyway
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_ff <= '0;
         is_wait_reg_ff <= 1'b0;
      end else if (state_ff == PBW_IDLE && req) begin
         req_ff.addr <= avs_address;
         req_ff.wdata <= avs_writedata;
         req_ff.be <= avs_byteenable;
         req_ff.we <= avs_write;
         is_wait_reg_ff <= (avs_address == pbw_pkg::WAIT_SEL_ADDR);
      end
   end

   // write lands at the completing edge, low byte lane only
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_sel_ff <= pbw_pkg::WAIT_SEL_RST;
      end else if (state_ff == PBW_DONE && is_wait_reg_ff &&
            req_ff.we && req_ff.be[0]) begin
         wait_sel_ff <= req_ff.wdata[7:0];
      end
   end

   // peripheral data sampled late in the window, after it has settled
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= '0;
      end else if (state_ff == PBW_COUNT && cnt_ff == '0) begin
         if (is_wait_reg_ff) begin
            rdata_ff <= {24'h000000, wait_sel_ff};
         end else begin
            rdata_ff <= per_rdata;
         end
      end
   end

   // peripheral strobes are registered so they stay clean for the window
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         per_sel <= 1'b0;
         per_we <= 1'b0;
      end else begin
         per_sel <= (nxt_state != PBW_IDLE) &&
                    !((state_ff == PBW_IDLE) ?
                      (avs_address == pbw_pkg::WAIT_SEL_ADDR) :
                      is_wait_reg_ff);
         per_we <= (nxt_state == PBW_DONE) && req_ff.we &&
                   !is_wait_reg_ff;
      end
   end

   assign per_addr = req_ff.addr;
   assign per_wdata = req_ff.wdata;
   assign per_be = req_ff.be;
   assign avs_readdata = rdata_ff;
   assign peripheral_wait_select = wait_sel_ff;
   // cpu stalls until every base and extra wait has run out
   assign avs_waitrequest = req && (state_ff != PBW_DONE);

endmodule

`default_nettype wire

// ===== design/pbw_pkg.sv
package pbw_pkg;
   // register index as printed; byte address is four times the index
   localparam logic [31:0] WAIT_SEL_IDX = 32'h0ffff06e;
   localparam logic [31:0] WAIT_SEL_ADDR = 32'h3fffc1b8;
   localparam logic [7:0] WAIT_SEL_RST = 8'h77;
   localparam int WAIT_M_LSB = 0;
   localparam int WAIT_M_MSB = 2;
   localparam logic [7:0] WAIT_SEL_NONE = 8'h00;
   localparam logic [7:0] WAIT_SEL_ONE = 8'h01;
   localparam int BASE_CYCLES = 3;
   localparam int EXTRA_BASE = 2;
   localparam int CNT_W = 9;
   localparam int K_W = 5;
   localparam logic [4:0] K_ZERO = 5'h00;
   localparam logic [4:0] K_ONE = 5'h01;
   localparam logic [4:0] K_TWO = 5'h02;
   localparam logic [4:0] K_THREE = 5'h03;
   localparam logic [4:0] K_FIVE = 5'h05;
   localparam logic [4:0] K_CSI_MAX = 5'h12;
   localparam logic [4:0] K_CSI_RX_MAX = 5'h14;
   localparam int SER_SPAN = 32;
   localparam int TMC_SPAN = 4;
   localparam int ASY_SPAN = 3;
   localparam int RTB_SPAN = 2;

   typedef enum logic [3:0] {
      PBW_PLAIN,
      PBW_WDT1_WR,
      PBW_WDT2_WR,
      PBW_TP_RD,
      PBW_TP_WR,
      PBW_TMC_RMW,
      PBW_CSI_WR,
      PBW_STAT_RD,
      PBW_RTB_WR
   } pbw_class_type;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
      logic we;
   } pbw_req_type;
endpackage

// ===== testbench/pbw_checker.sv
`timescale 1ns/100ps
`default_nettype none
module pbw_checker (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [31:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic avs_waitrequest,
   input wire logic per_sel,
   input wire logic per_we,
   input wire logic [7:0] peripheral_wait_select
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic wsel_wr;
   logic m0;
   logic req;
   logic [7:0] wd;
   assign wsel_wr = avs_write && !avs_waitrequest && avs_byteenable[0] &&
      avs_address == pbw_pkg::WAIT_SEL_ADDR;
   assign m0 = peripheral_wait_select[2:0] == 3'h0;
   assign req = avs_read || avs_write;
   assign wd = avs_writedata[7:0];
   AST_RST_VAL: assert property ($rose(rst_n) |->
      peripheral_wait_select == 8'h77) else $error("reset value");
   AST_WR_TAKES: assert property (wsel_wr |=>
      peripheral_wait_select == $past(wd)) else $error("write lost");
   AST_HOLD: assert property (!wsel_wr |=>
      $stable(peripheral_wait_select)) else $error("register moved");
   AST_MIN3: assert property ($rose(req) |->
      avs_waitrequest[*2]) else $error("answer too early");
   AST_PLAIN: assert property ($rose(avs_read) && m0 &&
      avs_address == 32'h800 |-> avs_waitrequest[*2] ##1 !avs_waitrequest)
      else $error("plain length");
   AST_WDT2: assert property ($rose(avs_write) && m0 &&
      avs_address == 32'h104 |-> avs_waitrequest[*8] ##1 !avs_waitrequest)
      else $error("watchdog two length");
   AST_ASY: assert property ($rose(avs_read) && m0 &&
      avs_address == 32'h500 |-> avs_waitrequest[*4] ##1 !avs_waitrequest)
      else $error("status read length");
   AST_PER_WE: assert property (per_we |->
      per_sel && avs_write && !avs_waitrequest) else $error("strobe early");
   cover property (wsel_wr);
   cover property ($rose(avs_write) && avs_address == 32'h300);
   cover property ($rose(per_we));
endmodule
bind pbw_bridge pbw_checker u_chk (.sys_clk, .rst_n, .avs_address,
   .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
   .avs_waitrequest, .per_sel, .per_we, .peripheral_wait_select);
`default_nettype wire

// ===== testbench/pbw_periph.sv
`timescale 1ns/100ps
`default_nettype none
module pbw_periph (
   input wire logic sys_clk,
   input wire logic per_sel,
   input wire logic [31:0] per_addr,
   output logic [31:0] per_rdata
);
   logic [31:0] junk_ff = 32'h0;
   always_ff @(posedge sys_clk) begin
      junk_ff <= junk_ff + 32'h9e3779b9;
   end
   // unselected bus moves every cycle so stale data cannot pass
   assign per_rdata = per_sel ? ~per_addr : junk_ff;
endmodule
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic cpu_rmw = 1'b0;
   logic rx = 1'b0;
   logic rte = 1'b0;
   logic [4:0] hk = 5'h0;
   logic [3:0] be = 4'h1;
   logic [3:0] per_be;
   logic [31:0] per_wdata, pw;
   logic [31:0] avs_address = 32'h0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, per_rdata, per_addr, rd, r, a;
   logic avs_waitrequest, per_sel, per_we;
   logic [7:0] wsel;
   logic [31:0] ta[12] = '{32'h800, 32'h100, 32'h104, 32'h208, 32'h200,
      32'h204, 32'h300, 32'h400, 32'h47c, 32'h500, 32'h510, 32'h604};
   int miscompares = 0;
   int tests_run = 0;
   int seed = 12239;
   int n, lim;
   always #25 sys_clk = ~sys_clk;
   pbw_bridge u_dut (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable(be), .avs_readdata, .avs_waitrequest,
      .cpu_rmw, .per_hold_k(hk), .per_rx_conflict(rx),
      .realtime_output_enable(rte), .per_rdata, .per_sel, .per_we, .per_addr,
      .per_wdata, .per_be, .peripheral_wait_select(wsel));
   pbw_periph u_per (.sys_clk, .per_sel, .per_addr, .per_rdata);
   // write strobe seen mid-cycle, so the value is settled before checking
   always @(negedge sys_clk) begin
      if (per_we) begin
         pw = per_wdata;
      end
   end
   task automatic stop_test;
      if (miscompares == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s exp %h got %h", what, exp, got);
      end
   endtask
   // holds the request until waitrequest is seen low, no fixed latency
   task automatic acc(input logic we, input logic [31:0] ad, d);
      logic w;
      @(posedge sys_clk);
      avs_address <= ad;
      avs_writedata <= d;
      avs_write <= we;
      avs_read <= !we;
      n = 0;
      // value settled mid-cycle is what the next rising edge sees
      do begin
         @(negedge sys_clk);
         w = avs_waitrequest;
         rd = avs_readdata;
         @(posedge sys_clk);
         n++;
      end while (w !== 1'b0 && n < 400);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   function automatic int kexp(logic we, logic [31:0] ad);
      case (ad[31:8])
         24'h1: return we ? (ad[2] ? 3 : int'(hk)) : 0;
         24'h2: return we ? (ad[3] ? 0 : int'(hk)) : 1;
         24'h3: return int'(we && cpu_rmw);
         24'h4: return we ? int'(hk) : 0;
         24'h5: return int'(!we);
         24'h6: return int'(we && !rte);
         default: return 0;
      endcase
   endfunction
   initial begin
      #2000000;
      miscompares++;
      stop_test();
   end
   initial begin
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      acc(1'b0, pbw_pkg::WAIT_SEL_ADDR, 32'h0);
      chk("reset wait sel", 32'h77, rd);
      chk("reset length", 10, n);
      // wait select goes first; only the main clock runs here
      for (int m = 1; m >= 0; m--) begin
         r = $random(seed);
         acc(1'b1, pbw_pkg::WAIT_SEL_ADDR, {r[31:8], 8'(m)});
         be <= 4'he;
         acc(1'b1, pbw_pkg::WAIT_SEL_ADDR, ~r);
         be <= 4'h1;
         acc(1'b0, pbw_pkg::WAIT_SEL_ADDR, 32'h0);
         chk("wait sel", m, rd);
         chk("wait sel length", 3 + m, n);
         for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            a = ta[i / 2];
            lim = a[31:8] == 24'h1 ? 5 : a[31:8] == 24'h2 ? 3 : r[31] ? 21 : 19;
            @(posedge sys_clk);
            rx <= r[31];
            rte <= r[30];
            cpu_rmw <= r[29];
            hk <= 5'((a[31:8] == 24'h1) + r[15:0] % lim);
            acc(i[0], a, r);
            chk("length", 3 + m + (2 + m) * kexp(i[0], a), n);
            if (!i[0]) chk("read data", ~a, rd);
            if (i[0]) chk("per wdata", r, pw);
            chk("per be", 32'h1, 32'(per_be));
         end
      end
      stop_test();
   end
endmodule
`default_nettype wire
